// ### gpioa_board.sv
// board model: resolves pin levels and supplies usb bypass clocks
`timescale 1ns/1ps
module gpioa_board (
  input  wire logic        core_clk_i,
  input  wire logic [15:0] pin_o,
  input  wire logic [15:0] pin_oe_o,
  input  wire logic [15:0] ext_i,
  input  wire logic        usbclk_en_i,
  output logic      [15:0] pin_lvl_o
);
  logic [1:0] div_reg = 2'h0;
  // free running bypass clock source at a quarter of the core rate
  always_ff @(posedge core_clk_i) begin
    div_reg <= div_reg + 2'h1;
  end
  // external clocks fed on pins 0 and 1
  always_comb begin
    pin_lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
    if (usbclk_en_i) begin
      pin_lvl_o[1:0] = {2{div_reg[1]}};
    end
  end
endmodule

// ### gpioa_clkgen.sv
// programmable clock divider driving one clock output pin
`timescale 1ns/1ps
module gpioa_clkgen
  import gpioa_pkg::*;
(
  input  wire logic            core_clk_i,
  input  wire logic            rstn_i,
  input  wire logic [CKW-1:0]  high_i,
  input  wire logic [CKW-1:0]  low_i,
  output logic                 clk_o
);
  logic [CKW-1:0] cnt_reg,  cnt_next;
  logic           clk_reg,  clk_next;
  logic [CKW-1:0] hi_eff, lo_eff;
  logic [CKW:0]   per;
  // period is clamped so the output never exceeds the ceiling
  always_comb begin
    hi_eff   = high_i;
    lo_eff   = low_i;
    per      = {1'b0, hi_eff} + {1'b0, lo_eff} + (CKW+1)'(2);
    if (per < (CKW+1)'(CK_MIN_CYC)) begin
      lo_eff = lo_eff + CKW'(1);
    end
    cnt_next = cnt_reg + CKW'(1);
    clk_next = clk_reg;
    if (clk_reg && cnt_reg >= hi_eff) begin
      clk_next = 1'b0;
      cnt_next = '0;
    end else if (!clk_reg && cnt_reg >= lo_eff) begin
      clk_next = 1'b1;
      cnt_next = '0;
    end
  end
  // registered divider state
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
      clk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end
  assign clk_o = clk_reg;
endmodule

// ### gpioa_pkg.sv
// package of register offsets, field positions and constants for the gpio port
package gpioa_pkg;
  localparam int NPINS = 16;
  localparam int NIRQ  = 13;
  localparam int AW    = 6;
  localparam int DW    = 32;
  // register byte offsets
  localparam logic [AW-1:0] OUT_OFS    = 6'h00;
  localparam logic [AW-1:0] DIR_OFS    = 6'h04;
  localparam logic [AW-1:0] IN_OFS     = 6'h08;
  localparam logic [AW-1:0] ITYPE_OFS  = 6'h0c;
  localparam logic [AW-1:0] ISTAT_OFS  = 6'h10;
  localparam logic [AW-1:0] IMASK_OFS  = 6'h14;
  localparam logic [AW-1:0] ALT_OFS    = 6'h18;
  localparam logic [AW-1:0] CLK14_OFS  = 6'h1c;
  localparam logic [AW-1:0] CLK15_OFS  = 6'h20;
  // trigger codes of pins 10 to 12 spill into a second word
  localparam logic [AW-1:0] ITYPE_HI_OFS = 6'h24;
  // direction register: 1 = input; pin 14 input, pin 15 output at reset
  localparam logic [15:0] DIR_RST      = 16'h7fff;
  // alt select bits
  localparam int ALT_USBDEV = 0;
  localparam int ALT_USBHST = 1;
  localparam int ALT_SNAPM  = 2;
  localparam int ALT_SNAPS  = 3;
  localparam int ALT_CLK14  = 4;
  localparam int ALT_CLK15  = 5;
  localparam logic [5:0] ALT_RST = 6'h20;
  localparam int PIN_USBDEV = 0;
  localparam int PIN_USBHST = 1;
  localparam int PIN_SNAPM  = 7;
  localparam int PIN_SNAPS  = 8;
  localparam int PIN_CK14   = 14;
  localparam int PIN_CK15   = 15;
  // clock output control: [3:0] high count, [7:4] low count, in core cycles minus one
  localparam int CKH_LSB = 0;
  localparam int CKL_LSB = 4;
  localparam int CKW     = 4;
  localparam logic [7:0] CK_RST = 8'h11;
  // interrupt trigger encodings, three bits per pin
  typedef enum logic [2:0] {
    GPIOA_TRG_HIGH = 3'b000,
    GPIOA_TRG_LOW  = 3'b001,
    GPIOA_TRG_RISE = 3'b010,
    GPIOA_TRG_FALL = 3'b011,
    GPIOA_TRG_EDGE = 3'b100
  } gpioa_trg_t;
  localparam int TRGW = 3;
  // trigger field split: ten pins in the low word, the rest in the high word
  localparam int ITLO_W = 30;
  localparam int ITHI_W = NIRQ*TRGW - ITLO_W;
  // shortest output period in core cycles, keeps the clock at or below 33.33 MHz
  localparam int CK_MIN_CYC = 3;
endpackage

// ### gpioa_port.sv
// sixteen pin gpio port with interrupts and alternate clock functions
//
// Overview of operation
// R1: sixteen pins, each individually a general input or general output
// R2: pins 0 to 12 can raise interrupts; pins 13 to 15 cannot
// R3: pin 1 can carry an external bypass clock for usb 2.0 host
// R4: pin 0 can carry an external bypass clock for usb 1.1 device
// R5: pins 14 and 15 can output a clock, programmable rate and duty
// R6: pin 14 is an input after reset
// R7: pin 15 is an output driving clock after reset
// R8: pin 15 clock after reset may feed the expansion bus
// R9: pin 7 feeds master snapshot, pin 8 slave snapshot
// R10: under spread spectrum clocking system should route usb clocks on pins 0,1
// R11: software writes direction and level, reads every pin level
// R12: each enabled interrupt pin raises its own request on its trigger
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module gpioa_port
  import gpioa_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic [gpioa_pkg::AW-1:0] addr_i,
  input  wire logic [gpioa_pkg::DW-1:0] wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [gpioa_pkg::DW-1:0] rdata_o,
  input  wire logic [15:0]              pin_i,
  output logic      [15:0]              pin_o,
  output logic      [15:0]              pin_oe_o,
  output logic      [12:0]              irq_req_o,
  output logic                          irq_o,
  output logic                          usb_dev_clk_o,
  output logic                          usb_host_clk_o,
  output logic                          snap_master_o,
  output logic                          snap_slave_o,
  output logic                          exp_clk_o
);
  import gpioa_pkg::*;

  logic [15:0]          out_reg,   out_next;
  logic [15:0]          dir_reg,   dir_next;
  logic [NIRQ*TRGW-1:0] itype_reg, itype_next;
  logic [NIRQ-1:0]      istat_reg, istat_next;
  logic [NIRQ-1:0]      imask_reg, imask_next;
  logic [5:0]           alt_reg,   alt_next;
  logic [7:0]           ck14_reg,  ck14_next;
  logic [7:0]           ck15_reg,  ck15_next;
  logic [DW-1:0]        rdata_reg, rdata_next;
  logic [15:0]          s1_reg, s2_reg, prev_reg;
  logic [15:0]          pin_reg,   pin_next;
  logic [15:0]          oe_reg,    oe_next;
  logic [NIRQ-1:0]      req_reg,   req_next;
  logic                 irq_reg,   irq_next;
  logic [3:0]           alt_in_reg, alt_in_next;
  logic                 exp_reg,   exp_next;
  logic                 ck14, ck15;
  logic [NIRQ-1:0]      trig;

  // register write decode
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // clock output dividers for pins 14 and 15
  // R5: programmable clock outputs
  gpioa_clkgen u_ck14 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .high_i     (ck14_reg[CKH_LSB +: CKW]),
    .low_i      (ck14_reg[CKL_LSB +: CKW]),
    .clk_o      (ck14)
  );
  gpioa_clkgen u_ck15 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .high_i     (ck15_reg[CKH_LSB +: CKW]),
    .low_i      (ck15_reg[CKL_LSB +: CKW]),
    .clk_o      (ck15)
  );

  // two flop synchroniser on the pin inputs, then one stage for edge history
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg   <= pin_i;
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  // per pin trigger detection on synchronised levels
  genvar g;
  generate
    for (g = 0; g < NIRQ; g++) begin : g_trig
      always_comb begin
        case (gpioa_trg_t'(itype_reg[g*TRGW +: TRGW]))
          GPIOA_TRG_HIGH: trig[g] = s2_reg[g];
          GPIOA_TRG_LOW:  trig[g] = !s2_reg[g];
          GPIOA_TRG_RISE: trig[g] = s2_reg[g] && !prev_reg[g];
          GPIOA_TRG_FALL: trig[g] = !s2_reg[g] && prev_reg[g];
          GPIOA_TRG_EDGE: trig[g] = s2_reg[g] ^ prev_reg[g];
          default:        trig[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // next state of software registers, status and read data
  always_comb begin
    out_next   = out_reg;
    dir_next   = dir_reg;
    itype_next = itype_reg;
    imask_next = imask_reg;
    alt_next   = alt_reg;
    ck14_next  = ck14_reg;
    ck15_next  = ck15_reg;
    rdata_next = '0;
    istat_next = istat_reg;
    if (wr_i) begin
      // R11: direction and level writes
      if (hit(addr_i, OUT_OFS))   out_next   = wdata_i[15:0];
      if (hit(addr_i, DIR_OFS))   dir_next   = wdata_i[15:0];
      if (hit(addr_i, ITYPE_OFS)) itype_next[ITLO_W-1:0] = wdata_i[ITLO_W-1:0];
      if (hit(addr_i, ITYPE_HI_OFS)) begin
        itype_next[NIRQ*TRGW-1:ITLO_W] = wdata_i[ITHI_W-1:0];
      end
      if (hit(addr_i, IMASK_OFS)) imask_next = wdata_i[NIRQ-1:0];
      if (hit(addr_i, ALT_OFS))   alt_next   = wdata_i[5:0];
      if (hit(addr_i, CLK14_OFS)) ck14_next  = wdata_i[7:0];
      if (hit(addr_i, CLK15_OFS)) ck15_next  = wdata_i[7:0];
      if (hit(addr_i, ISTAT_OFS)) istat_next = istat_reg & ~wdata_i[NIRQ-1:0];
    end
    // R2: only pins 0 to 12 set status; set wins over clear
    istat_next = istat_next | trig;
    if (rd_i) begin
      case (addr_i)
        OUT_OFS:   rdata_next = {16'h0000, out_reg};
        DIR_OFS:   rdata_next = {16'h0000, dir_reg};
        // R11: live pin levels
        IN_OFS:    rdata_next = {16'h0000, s2_reg};
        ITYPE_OFS: rdata_next = {{(DW-ITLO_W){1'b0}}, itype_reg[ITLO_W-1:0]};
        ITYPE_HI_OFS: begin
          rdata_next = {{(DW-ITHI_W){1'b0}}, itype_reg[NIRQ*TRGW-1:ITLO_W]};
        end
        ISTAT_OFS: rdata_next = {{(DW-NIRQ){1'b0}}, istat_reg};
        IMASK_OFS: rdata_next = {{(DW-NIRQ){1'b0}}, imask_reg};
        ALT_OFS:   rdata_next = {26'h0000000, alt_reg};
        CLK14_OFS: rdata_next = {24'h000000, ck14_reg};
        CLK15_OFS: rdata_next = {24'h000000, ck15_reg};
        default:   rdata_next = '0;
      endcase
    end
  end

  // pin drive, interrupt and alternate function outputs
  always_comb begin
    pin_next = out_reg;
    // R1: per pin direction, 1 selects input
    oe_next  = ~dir_reg;
    // R5: clock outputs override the level when selected and driven
    if (alt_reg[ALT_CLK14]) pin_next[PIN_CK14] = ck14;
    // R7: pin 15 drives its clock from reset
    if (alt_reg[ALT_CLK15]) pin_next[PIN_CK15] = ck15;
    // R4: usb device bypass clock pin stays input
    if (alt_reg[ALT_USBDEV]) oe_next[PIN_USBDEV] = 1'b0;
    // R3: usb host bypass clock pin stays input
    if (alt_reg[ALT_USBHST]) oe_next[PIN_USBHST] = 1'b0;
    // R9: snapshot pins stay inputs
    if (alt_reg[ALT_SNAPM]) oe_next[PIN_SNAPM] = 1'b0;
    if (alt_reg[ALT_SNAPS]) oe_next[PIN_SNAPS] = 1'b0;
    alt_in_next = {alt_reg[ALT_SNAPS]  & s2_reg[PIN_SNAPS],
                   alt_reg[ALT_SNAPM]  & s2_reg[PIN_SNAPM],
                   alt_reg[ALT_USBHST] & s2_reg[PIN_USBHST],
                   alt_reg[ALT_USBDEV] & s2_reg[PIN_USBDEV]};
    // R8: expansion bus clock from pin 15 divider
    exp_next = alt_reg[ALT_CLK15] & ck15;
    // R12: one request line per enabled pin
    req_next = istat_reg & imask_reg;
    irq_next = |(istat_reg & imask_reg);
  end

  // register all state
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_reg    <= '0;
      // R6: pin 14 input, R7: pin 15 output
      dir_reg    <= DIR_RST;
      itype_reg  <= '0;
      istat_reg  <= '0;
      imask_reg  <= '0;
      alt_reg    <= ALT_RST;
      ck14_reg   <= CK_RST;
      ck15_reg   <= CK_RST;
      rdata_reg  <= '0;
      pin_reg    <= '0;
      oe_reg     <= '0;
      req_reg    <= '0;
      irq_reg    <= 1'b0;
      alt_in_reg <= '0;
      exp_reg    <= 1'b0;
    end else begin
      out_reg    <= out_next;
      dir_reg    <= dir_next;
      itype_reg  <= itype_next;
      istat_reg  <= istat_next;
      imask_reg  <= imask_next;
      alt_reg    <= alt_next;
      ck14_reg   <= ck14_next;
      ck15_reg   <= ck15_next;
      rdata_reg  <= rdata_next;
      pin_reg    <= pin_next;
      oe_reg     <= oe_next;
      req_reg    <= req_next;
      irq_reg    <= irq_next;
      alt_in_reg <= alt_in_next;
      exp_reg    <= exp_next;
    end
  end

  assign rdata_o        = rdata_reg;
  assign pin_o          = pin_reg;
  assign pin_oe_o       = oe_reg;
  assign irq_req_o      = req_reg;
  assign irq_o          = irq_reg;
  assign usb_dev_clk_o  = alt_in_reg[0];
  assign usb_host_clk_o = alt_in_reg[1];
  assign snap_master_o  = alt_in_reg[2];
  assign snap_slave_o   = alt_in_reg[3];
  assign exp_clk_o      = exp_reg;
endmodule

// ### gpioa_port_properties.sv
// concurrent checks on the gpio port pins and register read path
`timescale 1ns/1ps
module gpioa_port_chk
  import gpioa_pkg::*;
(
  input wire logic                     core_clk_i,
  input wire logic                     rstn_i,
  input wire logic [gpioa_pkg::AW-1:0] addr_i,
  input wire logic                     rd_i,
  input wire logic [gpioa_pkg::DW-1:0] rdata_o,
  input wire logic [15:0]              pin_oe_o,
  input wire logic [12:0]              irq_req_o,
  input wire logic                     irq_o,
  input wire logic                     usb_dev_clk_o,
  input wire logic                     usb_host_clk_o,
  input wire logic                     snap_master_o,
  input wire logic                     snap_slave_o,
  input wire logic                     exp_clk_o
);
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // clock output steps: a rise, then two cycles with no new rise
  sequence s_ck_rise;
    $rose(exp_clk_o);
  endsequence
  sequence s_ck_gap;
    !$rose(exp_clk_o) [*2];
  endsequence
  chk_rd_slot_only: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (rd_i && addr_i > 6'h24 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_dirs: assert property ($rose(rstn_i) |=> pin_oe_o == 16'h8000)
    else $error("pin directions wrong after reset");
  chk_ck_ceiling: assert property (s_ck_rise |=> s_ck_gap)
    else $error("clock output above ceiling");
  chk_irq_follows: assert property ($rose(|irq_req_o) |-> ##[0:1] irq_o)
    else $error("irq output missing");
  chk_usbdev_input: assert property (usb_dev_clk_o |-> !pin_oe_o[0])
    else $error("pin 0 driven while bypass input");
  chk_usbhost_input: assert property (usb_host_clk_o |-> !pin_oe_o[1])
    else $error("pin 1 driven while bypass input");
  chk_snapm_input: assert property (snap_master_o |-> !pin_oe_o[7])
    else $error("pin 7 driven while snapshot input");
  chk_snaps_input: assert property (snap_slave_o |-> !pin_oe_o[8])
    else $error("pin 8 driven while snapshot input");
endmodule
bind gpioa_port gpioa_port_chk u_chk (.core_clk_i, .rstn_i, .addr_i, .rd_i, .rdata_o, .pin_oe_o,
  .irq_req_o, .irq_o, .usb_dev_clk_o, .usb_host_clk_o, .snap_master_o, .snap_slave_o,
  .exp_clk_o);

// ### gpioa_port_tb.sv
// self-checking testbench for the gpio port
`timescale 1ns/1ps
module gpioa_port_tb;
  import gpioa_pkg::*;
  logic          core_clk_i = 1'b0;
  logic          rstn_i     = 1'b0;
  logic [AW-1:0] addr_i     = 6'h00;
  logic [DW-1:0] wdata_i    = 32'h0;
  logic          wr_i       = 1'b0;
  logic          rd_i       = 1'b0;
  logic [15:0]   ext        = 16'h0000;
  logic          usbclk_en  = 1'b0;
  logic [4:0]    trig_exp   = 5'h17;
  logic [DW-1:0] rdata_o;
  logic [15:0]   pin_i, pin_o, pin_oe_o;
  logic [12:0]   irq_req_o;
  logic          irq_o, ud, uh, sm, ss, exp_clk_o;
  int            mismatches = 0;
  int            n_compared = 0;
  int            i, n0, n1;
  // core clock
  always #5 core_clk_i = ~core_clk_i;
  gpioa_port uut (.core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i,
    .pin_o, .pin_oe_o, .irq_req_o, .irq_o, .usb_dev_clk_o(ud), .usb_host_clk_o(uh),
    .snap_master_o(sm), .snap_slave_o(ss), .exp_clk_o);
  gpioa_board brd (.core_clk_i, .pin_o, .pin_oe_o, .ext_i(ext), .usbclk_en_i(usbclk_en),
    .pin_lvl_o(pin_i));
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // one-cycle register read, data checked in the following cycle
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // count rising edges of one clock-like output over 30 cycles
  task automatic cnt(input int sel, output int n);
    logic [3:0] w;
    logic       p;
    n = 0;
    p = 1'b1;
    repeat (30) begin
      @(posedge core_clk_i);
      #1 w = {exp_clk_o, pin_o[14], uh, ud};
      if (w[sel] && !p) n++;
      p = w[sel];
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    results();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    cyc(3);
    chk(32'(pin_oe_o), 32'h0000_8000);
    rd(DIR_OFS, 32'h0000_7fff);
    rd(ALT_OFS, 32'h0000_0020);
    rd(CLK15_OFS, 32'h0000_0011);
    cnt(3, n0);
    chk(32'(n0 inside {[32'h7:32'h8]}), 32'h1);
    wr(OUT_OFS, 32'h0000_a5a5);
    wr(DIR_OFS, 32'h0000_0000);
    cyc(2);
    chk(32'(pin_oe_o), 32'h0000_ffff);
    chk(32'(pin_o[14:0]), 32'h0000_25a5);
    wr(DIR_OFS, 32'h0000_ffff);
    ext <= 16'h3c5a;
    cyc(4);
    rd(IN_OFS, 32'h0000_3c5a);
    wr(IN_OFS, 32'h0000_ffff);
    rd(IN_OFS, 32'h0000_3c5a);
    rd(6'h28, 32'h0);
    wr(IMASK_OFS, 32'h0000_0008);
    for (i = 0; i < 5; i++) begin
      wr(ITYPE_OFS, 32'(i) << 9);
      ext <= 16'h0000;
      cyc(6);
      wr(ISTAT_OFS, 32'h0000_1fff);
      ext <= 16'h0008;
      cyc(6);
      chk(32'(irq_req_o), {28'h0, trig_exp[i], 3'h0});
      chk(32'(irq_o), 32'(trig_exp[i]));
      rd(ISTAT_OFS, {28'h0, trig_exp[i], 3'h0});
    end
    wr(ITYPE_OFS, 32'h0);
    wr(ITYPE_HI_OFS, 32'h0000_01ff);
    rd(ITYPE_HI_OFS, 32'h0000_01ff);
    wr(ITYPE_HI_OFS, 32'h0);
    ext <= 16'hffff;
    cyc(6);
    rd(ISTAT_OFS, 32'h0000_1fff);
    wr(IMASK_OFS, 32'h0);
    cyc(2);
    chk(32'(irq_o), 32'h0);
    wr(DIR_OFS, 32'h0000_0000);
    wr(ALT_OFS, 32'h0000_002f);
    ext <= 16'h0180;
    usbclk_en <= 1'b1;
    cyc(6);
    chk(32'(pin_oe_o[8:0]), 32'h0000_007c);
    chk(32'({sm, ss}), 32'h3);
    cnt(0, n0);
    cnt(1, n1);
    chk(32'(n0 > 4 && n1 > 4), 32'h1);
    wr(CLK14_OFS, 32'h0000_0000);
    wr(CLK15_OFS, 32'h0000_0031);
    wr(ALT_OFS, 32'h0000_0030);
    cyc(4);
    cnt(2, n0);
    cnt(3, n1);
    chk(32'(n0 inside {[32'h9:32'ha]}), 32'h1);
    chk(32'(n1 inside {[32'h4:32'h5]}), 32'h1);
    results();
  end
endmodule
